// ---- rtl/acspd_pkg.sv ----
/*
  Package for the audio clock source and PLL divider configuration block.
  Holds register offsets, field positions, reset values and source indices.
  Assumes a classic Wishbone slave with 8-bit data in the low lanes.
*/
package acspd_pkg;

  // ****************************************
  // Register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [7:0] IDX_SEC_BITCLK_SRC = 8'h33;
  localparam logic [7:0] IDX_NM_SRC_SEL = 8'h34;
  localparam logic [7:0] IDX_PLL_PRESCALE = 8'h35;
  localparam logic [7:0] IDX_PLL_MULT_UPPER = 8'h36;
  localparam logic [7:0] IDX_PLL_MULT_LOWER = 8'h37;
  localparam logic [7:0] IDX_PLL_INT_LOWER = 8'h38;
  localparam logic [7:0] IDX_PLL_CTRL = 8'h3A;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_SEC_BITCLK_SRC = 8'h00;
  localparam logic [7:0] RST_NM_SRC_SEL = 8'h10;
  localparam logic [7:0] RST_PLL_PRESCALE = 8'h01;
  localparam logic [7:0] RST_PLL_MULT_UPPER = 8'h00;
  localparam logic [7:0] RST_PLL_MULT_LOWER = 8'h00;
  localparam logic [7:0] RST_PLL_INT_LOWER = 8'h08;
  localparam logic [7:0] RST_PLL_CTRL = 8'h00;

  // ****************************************
  // Writable masks (reserved bits read zero)
  // ****************************************
  localparam logic [7:0] MASK_SEC_BITCLK_SRC = 8'h70;
  localparam logic [7:0] MASK_NM_SRC_SEL = 8'hF0;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_PLL_CTRL = 8'h01;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SEC_SRC_LSB = 4;
  localparam int DIG_NM_LSB = 6;
  localparam int ANA_NM_LSB = 4;
  localparam int INT_TOP_BIT = 7;
  localparam int HALVING_BIT = 6;
  localparam int AUTO_DETECT_BIT = 0;

  // ****************************************
  // Limits and auto-detect defaults
  // ****************************************
  localparam logic [13:0] FRAC_MULT_MAX = 14'h270F;
  localparam logic [8:0] PRESCALE_ZERO_DIV = 9'h100;
  localparam logic [8:0] AUTO_PRESCALE_DIV = 9'h001;

  // ****************************************
  // Clock source indices on the source vector
  // ****************************************
  localparam int SRC_PLL = 0;
  localparam int SRC_PRI_BCLK = 1;
  localparam int SRC_SEC_BCLK = 2;
  localparam int SRC_CODEC_CLK = 3;
  localparam int SRC_OSC = 4;
  localparam int SRC_DSP = 5;
  localparam int SRC_COUNT = 6;

endpackage

// ---- rtl/acspd_clk_mux.sv ----
/*
  Clock source selector: picks one source by index, or holds the output low
  when the code is not valid. Assumes sources are glitch-safe gated upstream.
*/
`timescale 1ns/1ps
module acspd_clk_mux #(
  parameter int N = 6
) (
  input wire logic [N-1:0] src_i, // Candidate clocks
  input wire logic [2:0] sel_i, // Source index
  input wire logic valid_i, // Code is a legal source
  output logic clk_o // Gated selected clock
);

  // Gate off rather than pass an undefined source
  always_comb begin
    clk_o = 1'b0;
    if (valid_i && (int'(sel_i) < N)) begin
      clk_o = src_i[sel_i];
    end
  end

endmodule

// ---- rtl/acspd_top.sv ----
/*
  Clock configuration block of a stereo audio codec: source selects for the
  secondary serial bit-clock divider and NM dividers, PLL pre-scale value and
  multiplier assembly. Registers are reached over classic Wishbone, 8-bit
  data in the low byte of a 32-bit word, one register per aligned word.
  Assumes all clock inputs are already usable by the downstream dividers.
  Assumes the master holds every request until it samples ack or err high.
  Selects should change only while the sources are stable, since the
  selectors are plain combinational muxes and can glitch on a live switch.
  Register 0x3A bit 0 stands in for the automatic ratio detection enable;
  0x37 and 0x38 hold the lower multiplier bytes joined to 0x36.
  Reserved source codes hold the selected divider clock low.
*/
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module acspd_top (
  input wire logic clk_i, // System clock, 25 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [9:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic wb_err_o, // Wishbone error, unmapped address
  input wire logic pll_clk_i, // PLL output clock
  input wire logic pri_bitclk_i, // Primary serial bit clock
  input wire logic sec_bitclk_i, // Secondary serial bit clock
  input wire logic codec_clock_input_i, // Codec clock input
  input wire logic osc_clk_i, // Internal oscillator clock
  input wire logic dsp_clk_i, // DSP clock
  output logic sec_div_clk_o, // Secondary bit-clock divider source
  output logic dig_nm_clk_o, // Digital NM divider source
  output logic ana_nm_clk_o, // Analog NM divider source
  output logic ana_nm_low_jitter_o, // Analog NM uses low-jitter bitclk path
  output logic [8:0] pll_prescale_div_o, // Effective pre-scale divide, 1..256
  output logic [8:0] pll_int_mult_o, // Integer multiplier
  output logic [13:0] pll_frac_mult_o, // Fraction multiplier
  output logic pll_frac_mult_bad_o, // Fraction multiplier above 9999
  output logic pll_divclk_halving_o, // PLL divides divided clock by two
  output logic pll_auto_detect_o // Auto ratio detection enabled
);

  // ****************************************
  // Register storage
  // ****************************************
  // Software-visible register copies
  logic [7:0] second_port_bitclk_div_src_reg;
  logic [7:0] nm_divider_source_select;
  logic [7:0] pll_prescale_divider;
  logic [7:0] pll_multiplier_upper_bits;
  logic [7:0] pll_frac_mult_lower;
  logic [7:0] pll_int_mult_lower;
  logic [7:0] pll_ctrl;
  // Next values from the write decode
  logic [7:0] next_sec_src;
  logic [7:0] next_nm_src;
  logic [7:0] next_prescale;
  logic [7:0] next_mult_upper;
  logic [7:0] next_frac_lower;
  logic [7:0] next_int_lower;
  logic [7:0] next_ctrl;
  // Bus answer state, registered, and its combinational next values
  logic wb_ack;
  logic wb_err;
  logic [7:0] rdata;
  logic next_ack;
  logic next_err;
  logic [7:0] next_rdata;

  // ****************************************
  // Bus decode
  // ****************************************
  logic req;
  logic [7:0] idx;
  logic hit;
  logic wr;
  // A request is taken only while no answer stands
  assign req = wb_cyc_i && wb_stb_i && !wb_ack && !wb_err;
  assign idx = wb_adr_i[9:2];
  // Write lands at the edge where the master samples ack high, so a request
  // dropped before its answer never changes state; sel[0] gates the low lane
  assign wr = wb_ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && hit;

  // Address map lookup and read mux
  always_comb begin
    hit = 1'b1;
    next_rdata = 8'h00;
    unique case (idx)
      acspd_pkg::IDX_SEC_BITCLK_SRC: next_rdata = second_port_bitclk_div_src_reg;
      acspd_pkg::IDX_NM_SRC_SEL: next_rdata = nm_divider_source_select;
      acspd_pkg::IDX_PLL_PRESCALE: next_rdata = pll_prescale_divider;
      acspd_pkg::IDX_PLL_MULT_UPPER: next_rdata = pll_multiplier_upper_bits;
      acspd_pkg::IDX_PLL_MULT_LOWER: next_rdata = pll_frac_mult_lower;
      acspd_pkg::IDX_PLL_INT_LOWER: next_rdata = pll_int_mult_lower;
      acspd_pkg::IDX_PLL_CTRL: next_rdata = pll_ctrl;
      default: hit = 1'b0;
    endcase
  end

  // One-cycle answer; ack or err drops the cycle after it was given
  always_comb begin
    next_ack = req && hit;
    next_err = req && !hit;
  end

  // Read data is registered with the answer so it stands while ack does
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack <= 1'b0;
      wb_err <= 1'b0;
      rdata <= 8'h00;
    end else begin
      wb_ack <= next_ack;
      wb_err <= next_err;
      rdata <= next_rdata;
    end
  end

  // Upper lanes always read zero
  assign wb_ack_o = wb_ack;
  assign wb_err_o = wb_err;
  assign wb_dat_o = {24'h000000, rdata};

  // ****************************************
  // Register writes
  // ****************************************
  // Writes are masked so reserved bits always hold zero
  always_comb begin
    next_sec_src = second_port_bitclk_div_src_reg;
    next_nm_src = nm_divider_source_select;
    next_prescale = pll_prescale_divider;
    next_mult_upper = pll_multiplier_upper_bits;
    next_frac_lower = pll_frac_mult_lower;
    next_int_lower = pll_int_mult_lower;
    next_ctrl = pll_ctrl;
    // Hold by default; only the addressed register moves
    if (wr) begin
      unique case (idx)
        acspd_pkg::IDX_SEC_BITCLK_SRC: next_sec_src = wb_dat_i[7:0] & acspd_pkg::MASK_SEC_BITCLK_SRC;
        acspd_pkg::IDX_NM_SRC_SEL: next_nm_src = wb_dat_i[7:0] & acspd_pkg::MASK_NM_SRC_SEL;
        acspd_pkg::IDX_PLL_PRESCALE: next_prescale = wb_dat_i[7:0] & acspd_pkg::MASK_FULL;
        acspd_pkg::IDX_PLL_MULT_UPPER: next_mult_upper = wb_dat_i[7:0] & acspd_pkg::MASK_FULL;
        acspd_pkg::IDX_PLL_MULT_LOWER: next_frac_lower = wb_dat_i[7:0] & acspd_pkg::MASK_FULL;
        acspd_pkg::IDX_PLL_INT_LOWER: next_int_lower = wb_dat_i[7:0] & acspd_pkg::MASK_FULL;
        acspd_pkg::IDX_PLL_CTRL: next_ctrl = wb_dat_i[7:0] & acspd_pkg::MASK_PLL_CTRL;
        default: ;
      endcase
    end
  end

  // Reset values as documented per register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      second_port_bitclk_div_src_reg <= acspd_pkg::RST_SEC_BITCLK_SRC;
      nm_divider_source_select <= acspd_pkg::RST_NM_SRC_SEL;
      pll_prescale_divider <= acspd_pkg::RST_PLL_PRESCALE;
      pll_multiplier_upper_bits <= acspd_pkg::RST_PLL_MULT_UPPER;
      pll_frac_mult_lower <= acspd_pkg::RST_PLL_MULT_LOWER;
      pll_int_mult_lower <= acspd_pkg::RST_PLL_INT_LOWER;
      pll_ctrl <= acspd_pkg::RST_PLL_CTRL;
    end else begin
      second_port_bitclk_div_src_reg <= next_sec_src;
      nm_divider_source_select <= next_nm_src;
      pll_prescale_divider <= next_prescale;
      pll_multiplier_upper_bits <= next_mult_upper;
      pll_frac_mult_lower <= next_frac_lower;
      pll_int_mult_lower <= next_int_lower;
      pll_ctrl <= next_ctrl;
    end
  end

  // ****************************************
  // Field extraction
  // ****************************************
  logic [2:0] second_port_bitclk_div_src;
  logic [1:0] digital_nm_div_src;
  logic [1:0] analog_nm_div_src;
  logic [7:0] pll_prescale_value;
  logic pll_int_mult_top_bit;
  logic pll_divclk_halving;
  logic [5:0] pll_frac_mult_upper;
  logic auto_detect;
  // Field slices of the stored registers
  assign second_port_bitclk_div_src = second_port_bitclk_div_src_reg[acspd_pkg::SEC_SRC_LSB +: 3];
  assign digital_nm_div_src = nm_divider_source_select[acspd_pkg::DIG_NM_LSB +: 2];
  assign analog_nm_div_src = nm_divider_source_select[acspd_pkg::ANA_NM_LSB +: 2];
  assign pll_prescale_value = pll_prescale_divider;
  assign pll_int_mult_top_bit = pll_multiplier_upper_bits[acspd_pkg::INT_TOP_BIT];
  assign pll_divclk_halving = pll_multiplier_upper_bits[acspd_pkg::HALVING_BIT];
  assign pll_frac_mult_upper = pll_multiplier_upper_bits[5:0];
  // Auto detect enable sits in the stand-in control register
  assign auto_detect = pll_ctrl[acspd_pkg::AUTO_DETECT_BIT];

  // ****************************************
  // Source selection
  // ****************************************
  // Source indices per selector; analog reuses the digital index
  logic [acspd_pkg::SRC_COUNT-1:0] srcs;
  logic [2:0] sec_idx;
  logic sec_ok;
  logic [2:0] dig_idx;
  logic [2:0] ana_idx;
  logic dig_clk;
  // Bit order must match the package source indices
  assign srcs = {dsp_clk_i, osc_clk_i, codec_clock_input_i, sec_bitclk_i, pri_bitclk_i, pll_clk_i};

  // Code to source index; reserved codes flagged invalid
  always_comb begin
    sec_idx = 3'(acspd_pkg::SRC_PLL);
    sec_ok = 1'b1;
    unique case (second_port_bitclk_div_src)
      3'h0: sec_idx = 3'(acspd_pkg::SRC_PLL);
      3'h1: sec_idx = 3'(acspd_pkg::SRC_PRI_BCLK);
      3'h3: sec_idx = 3'(acspd_pkg::SRC_CODEC_CLK);
      3'h4: sec_idx = 3'(acspd_pkg::SRC_OSC);
      3'h5: sec_idx = 3'(acspd_pkg::SRC_DSP);
      default: sec_ok = 1'b0;
    endcase
  end

  // Digital NM source: all four codes legal
  always_comb begin
    unique case (digital_nm_div_src)
      2'h0: dig_idx = 3'(acspd_pkg::SRC_PRI_BCLK);
      2'h1: dig_idx = 3'(acspd_pkg::SRC_SEC_BCLK);
      2'h2: dig_idx = 3'(acspd_pkg::SRC_CODEC_CLK);
      2'h3: dig_idx = 3'(acspd_pkg::SRC_OSC);
    endcase
  end

  // Analog NM: codes 0 and 1 both PLL; code 2 follows digital choice
  always_comb begin
    unique case (analog_nm_div_src)
      2'h0, 2'h1: ana_idx = 3'(acspd_pkg::SRC_PLL);
      2'h2: ana_idx = dig_idx;
      2'h3: ana_idx = 3'(acspd_pkg::SRC_PRI_BCLK);
    endcase
  end

  // Secondary divider clock, gated for reserved codes
  acspd_clk_mux #(.N(acspd_pkg::SRC_COUNT)) u_sec_mux (
    .src_i(srcs),
    .sel_i(sec_idx),
    .valid_i(sec_ok),
    .clk_o(sec_div_clk_o)
  );

  // Digital NM divider clock; every code is legal
  acspd_clk_mux #(.N(acspd_pkg::SRC_COUNT)) u_dig_mux (
    .src_i(srcs),
    .sel_i(dig_idx),
    .valid_i(1'b1),
    .clk_o(dig_clk)
  );

  // Analog NM divider clock; every code is legal
  acspd_clk_mux #(.N(acspd_pkg::SRC_COUNT)) u_ana_mux (
    .src_i(srcs),
    .sel_i(ana_idx),
    .valid_i(1'b1),
    .clk_o(ana_nm_clk_o)
  );

  // Low-jitter flag follows the register, not the clock path
  assign dig_nm_clk_o = dig_clk;
  assign ana_nm_low_jitter_o = (analog_nm_div_src == 2'h3);

  // ****************************************
  // PLL divider and multiplier values
  // ****************************************
  // Zero encodes 256; auto detection takes over the value
  always_comb begin
    if (auto_detect) begin
      pll_prescale_div_o = acspd_pkg::AUTO_PRESCALE_DIV;
    end else if (pll_prescale_value == 8'h00) begin
      pll_prescale_div_o = acspd_pkg::PRESCALE_ZERO_DIV;
    end else begin
      pll_prescale_div_o = {1'b0, pll_prescale_value};
    end
  end

  // Concatenated fraction multiplier; values above the limit are flagged
  assign pll_frac_mult_o = {pll_frac_mult_upper, pll_frac_mult_lower};
  assign pll_frac_mult_bad_o = ({pll_frac_mult_upper, pll_frac_mult_lower} > acspd_pkg::FRAC_MULT_MAX);
  // Integer multiplier and control bits pass straight through
  assign pll_int_mult_o = {pll_int_mult_top_bit, pll_int_mult_lower};
  assign pll_divclk_halving_o = pll_divclk_halving;
  assign pll_auto_detect_o = auto_detect;

endmodule

// ---- tb/acspd_properties.sv ----
/* Checker for the clock configuration block: bus answers and derived outputs.
   Sees only the top-level ports; bound to acspd_top after the module. */
`timescale 1ns/1ps
module acspd_properties (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [9:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic wb_err_o, // Error
  input wire logic pri_bitclk_i, // Primary bit clock
  input wire logic ana_nm_clk_o, // Analog NM source
  input wire logic ana_nm_low_jitter_o, // Low-jitter flag
  input wire logic [8:0] pll_prescale_div_o, // Pre-scale divide
  input wire logic [13:0] pll_frac_mult_o, // Fraction multiplier
  input wire logic pll_frac_mult_bad_o, // Fraction out of range
  input wire logic pll_divclk_halving_o, // Halving control
  input wire logic pll_auto_detect_o // Auto detect
);
  // ****************************************
  // Sequences and properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  localparam logic [13:0] FRAC_LIMIT = 14'h270F;
  // Taken only while no answer stands, else a held strobe would count twice
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_write(idx);
    s_taken ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == idx);
  endsequence
  property p_answer;
    s_taken |=> (wb_ack_o ^ wb_err_o);
  endproperty
  property p_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_unmapped;
    s_taken ##0 !(wb_adr_i[9:2] inside {8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h3A}) |=> wb_err_o && !wb_ack_o;
  endproperty
  property p_rsv_read;
    s_taken ##0 (!wb_we_i && wb_adr_i[9:2] == 8'h33) |=> (wb_dat_o & 32'hFFFFFF8F) == 32'h00000000;
  endproperty
  property p_prescale_zero;
    s_write(8'h35) ##0 (wb_dat_i[7:0] == 8'h00 && !pll_auto_detect_o) |=> ##1 pll_prescale_div_o == 9'h100;
  endproperty
  property p_auto;
    pll_auto_detect_o |-> pll_prescale_div_o == 9'h001;
  endproperty
  property p_halving;
    s_write(8'h36) |=> ##1 pll_divclk_halving_o == $past(wb_dat_i[6], 2);
  endproperty
  property p_frac_upper;
    s_write(8'h36) |=> ##1 pll_frac_mult_o[13:8] == $past(wb_dat_i[5:0], 2);
  endproperty
  property p_frac_bad;
    pll_frac_mult_bad_o == (pll_frac_mult_o > FRAC_LIMIT);
  endproperty
  property p_low_jitter;
    ana_nm_low_jitter_o |-> ana_nm_clk_o == pri_bitclk_i;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered next cycle");
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_rsv_read: assert property (p_rsv_read) else $error("reserved bits read nonzero");
  a_prescale_zero: assert property (p_prescale_zero) else $error("zero code not 256");
  a_auto: assert property (p_auto) else $error("auto detect kept programmed divide");
  a_halving: assert property (p_halving) else $error("halving bit wrong");
  a_frac_upper: assert property (p_frac_upper) else $error("fraction upper bits wrong");
  a_frac_bad: assert property (p_frac_bad) else $error("fraction range flag wrong");
  a_low_jitter: assert property (p_low_jitter) else $error("low-jitter path not primary clock");
endmodule
bind acspd_top acspd_properties chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .pri_bitclk_i, .ana_nm_clk_o, .ana_nm_low_jitter_o,
  .pll_prescale_div_o, .pll_frac_mult_o, .pll_frac_mult_bad_o, .pll_divclk_halving_o, .pll_auto_detect_o);

// ---- tb/acspd_testbench.sv ----
/* Self-checking bench for the clock configuration block.
   Drives Wishbone and holds the six clock sources at static levels. */
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, last_err;
  logic [9:0] adr = 10'h000;
  logic [3:0] wsel = 4'hF;
  logic [31:0] wdat = 32'h00000000, rdat;
  logic [5:0] src = 6'h00;
  logic ack, err, sec_o, dig_o, ana_o, lj_o, halv_o, bad_o, auto_o;
  logic [8:0] pre_o, int_o;
  logic [13:0] frac_o;
  int mismatches = 0, n_tests = 0, cycles = 0;
  // Source bit order follows the package source indices
  acspd_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .pll_clk_i(src[0]),
    .pri_bitclk_i(src[1]), .sec_bitclk_i(src[2]), .codec_clock_input_i(src[3]), .osc_clk_i(src[4]),
    .dsp_clk_i(src[5]), .sec_div_clk_o(sec_o), .dig_nm_clk_o(dig_o), .ana_nm_clk_o(ana_o),
    .ana_nm_low_jitter_o(lj_o), .pll_prescale_div_o(pre_o), .pll_int_mult_o(int_o), .pll_frac_mult_o(frac_o),
    .pll_frac_mult_bad_o(bad_o), .pll_divclk_halving_o(halv_o), .pll_auto_detect_o(auto_o));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until ack or err is sampled high; timeout cuts a hang
  task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    last_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(idx, 1'b1, d, q);
    // Write lands at the ack edge; read outputs one edge later
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] q;
    wb(idx, 1'b0, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask
  // Chosen source driven alone, then alone low; s below zero means gated
  task automatic mux_chk(input int which, input int s);
    logic o;
    for (int k = 0; k < 2; k++) begin
      src <= (s < 0) ? 6'h3F : ((6'h01 << s) ^ {6{k[0]}});
      @(posedge clk_i);
      o = (which == 0) ? sec_o : (which == 1) ? dig_o : ana_o;
      chk({31'h0, o}, (s >= 0 && k == 0) ? 32'h1 : 32'h0);
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk(8'h33, 8'h00);
    rd_chk(8'h34, 8'h10);
    rd_chk(8'h35, 8'h01);
    rd_chk(8'h36, 8'h00);
    chk(32'(pre_o), 32'h1);
    $display("reset test done");
  endtask
  task automatic t_sec();
    int tbl[8] = '{0, 1, -1, 3, 4, 5, -1, -1};
    for (int c = 0; c < 8; c++) begin
      wr(8'h33, 8'(c << 4));
      rd_chk(8'h33, 8'(c << 4));
      mux_chk(0, tbl[c]);
    end
    $display("secondary source test done");
  endtask
  task automatic t_nm();
    int dt[4] = '{1, 2, 3, 4};
    for (int d = 0; d < 4; d++)
      for (int a = 0; a < 4; a++) begin
        wr(8'h34, 8'((d << 6) | (a << 4)));
        rd_chk(8'h34, 8'((d << 6) | (a << 4)));
        mux_chk(1, dt[d]);
        mux_chk(2, a < 2 ? 0 : a == 2 ? dt[d] : 1);
        chk({31'h0, lj_o}, {31'h0, a == 3});
      end
    $display("NM source test done");
  endtask
  task automatic t_pll();
    int pv[4] = '{0, 1, 255, 128};
    for (int i = 0; i < 4; i++) begin
      wr(8'h35, 8'(pv[i]));
      chk(32'(pre_o), pv[i] == 0 ? 32'h100 : 32'(pv[i]));
    end
    wr(8'h3A, 8'h01);
    chk(32'(pre_o), 32'h1);
    chk({31'h0, auto_o}, 32'h1);
    wr(8'h3A, 8'h00);
    chk(32'(pre_o), 32'h80);
    wr(8'h36, 8'hC5);
    rd_chk(8'h36, 8'hC5);
    chk({22'h0, int_o, halv_o}, 32'h211);
    chk(32'(frac_o), 32'h0500);
    wr(8'h36, 8'h27);
    wr(8'h37, 8'h0F);
    chk({16'h0, frac_o, bad_o, halv_o}, 32'h9C3C);
    wr(8'h37, 8'h10);
    chk({31'h0, bad_o}, 32'h1);
    $display("PLL test done");
  endtask
  task automatic t_bus();
    logic [31:0] q;
    wsel <= 4'hE;
    wr(8'h35, 8'h22);
    wsel <= 4'hF;
    rd_chk(8'h35, 8'h80);
    wb(8'h39, 1'b0, 8'h00, q);
    chk({31'h0, last_err}, 32'h1);
    $display("bus test done");
  endtask
  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_sec();
    t_nm();
    t_pll();
    t_bus();
    test_done();
  end
endmodule
